/* ssp_pkg.sv */
// Constants for the SPI-mode synchronous serial port: register map,
// field positions, reset values, mode codes and master bit-rate counts.
// Assumes a single 125 MHz system clock that is also the oscillator rate.
package ssp_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses on the APB
  // ----------------------------------------------------------------
  localparam logic [7:0] SSP_ADDR_BUF  = 8'h10; // Transfer buffer
  localparam logic [7:0] SSP_ADDR_CTL  = 8'h14; // serial_port_control
  localparam logic [7:0] SSP_ADDR_DIR  = 8'h18; // Pin direction bits
  localparam logic [7:0] SSP_ADDR_STAT = 8'h94; // serial_port_status

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_WRITE_COLLISION_FLAG = 7;
  localparam int CTL_OV   = 6;
  localparam int CTL_EN   = 5;
  localparam int CTL_CKP  = 4;
  localparam int ST_SMP   = 7;
  localparam int ST_CKE   = 6;
  localparam int ST_BF    = 0;
  localparam int DIR_SCK  = 0;
  localparam int DIR_SDO  = 1;
  localparam int DIR_SS   = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [2:0] DIR_RESET  = 3'h7;

  // ----------------------------------------------------------------
  // Mode field codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_M_DIV4  = 4'h0;
  localparam logic [3:0] MODE_M_DIV16 = 4'h1;
  localparam logic [3:0] MODE_M_DIV64 = 4'h2;
  localparam logic [3:0] MODE_M_TMR   = 4'h3;
  localparam logic [3:0] MODE_S_SEL   = 4'h4;
  localparam logic [3:0] MODE_S_NOSEL = 4'h5;

  // ----------------------------------------------------------------
  // Master bit period in oscillator cycles, and half periods less one
  // ----------------------------------------------------------------
  localparam int FOSC_DIV_A = 4;
  localparam int FOSC_DIV_B = 16;
  localparam int FOSC_DIV_C = 64;
  localparam logic [4:0] HALF_A = 5'(FOSC_DIV_A / 2 - 1);
  localparam logic [4:0] HALF_B = 5'(FOSC_DIV_B / 2 - 1);
  localparam logic [4:0] HALF_C = 5'(FOSC_DIV_C / 2 - 1);
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // Shifter states
  typedef enum logic [2:0] {
    SSP_IDLE = 3'b001,
    SSP_MRUN = 3'b010,
    SSP_SRUN = 3'b100
  } ssp_state_t;

endpackage

/* ssp_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clock; reset is synchronous.
`timescale 1ns/100ps
module ssp_sync #(
  parameter int WIDTH = 1
) (
  // System
  input  wire logic             clock,
  input  wire logic             rst,
  // Pins and synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* ssp_spi.sv */
// SPI-mode synchronous serial port with APB register access.
// Assumes one 125 MHz clock, synchronous active-high reset, pins
// resolved outside from the output enables (low = driving).
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module ssp_spi
  import ssp_pkg::*;
(
  // System
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             sdo_oe_n,
  input  wire logic        slave_select_n,
  // System events
  input  wire logic        timer_two_tick,
  input  wire logic        sleep_mode,
  output logic             port_interrupt_flag,
  output logic             wake
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic       write_collision_flag, receive_overflow_flag, port_enable_bit;
  logic       clock_idle_polarity, sample_phase_select, clock_edge_select;
  logic       buffer_full_flag, read_stale, out_bit, late_pend, sck_d;
  logic [3:0] mode_field, bit_cnt;
  logic [2:0] pin_dir;
  logic [7:0] transfer_buffer, shift_register;
  logic [4:0] half_cnt, div_cnt;
  ssp_state_t state;
  logic [2:0] pins_sync;

  // Pin inputs through two flops
  ssp_sync #(.WIDTH(3)) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({sck_in, serial_in_pin, slave_select_n}),
    .sync_out (pins_sync)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire s_sck = pins_sync[2];
  wire s_sdi = pins_sync[1];
  wire s_ssn = pins_sync[0];
  wire acc      = psel & penable;
  wire reg_wr   = acc & pwrite;
  wire hit_buf  = (paddr == SSP_ADDR_BUF);
  wire hit_ctl  = (paddr == SSP_ADDR_CTL);
  wire hit_stat = (paddr == SSP_ADDR_STAT);
  wire hit_dir  = (paddr == SSP_ADDR_DIR);
  wire mapped   = hit_buf | hit_ctl | hit_stat | hit_dir;
  wire buf_wr   = reg_wr & hit_buf;
  wire buf_rd   = acc & ~pwrite & hit_buf;
  wire setup_rd = psel & ~penable & ~pwrite;

  // Mode selection
  wire is_master = port_enable_bit & (mode_field <= MODE_M_TMR);
  wire is_slave  = port_enable_bit & ((mode_field == MODE_S_SEL) |
                                      (mode_field == MODE_S_NOSEL));
  wire ss_ctl    = is_slave & (mode_field == MODE_S_SEL) & pin_dir[DIR_SS];
  wire selected  = ~ss_ctl | ~s_ssn;
  wire busy      = (state != SSP_IDLE);

  // Master half-period tick from the divider or timer
  wire [4:0] half_lim = (mode_field == MODE_M_DIV4)  ? HALF_A :
                        (mode_field == MODE_M_DIV16) ? HALF_B : HALF_C;
  wire m_tick = (state == SSP_MRUN) &
                ((mode_field == MODE_M_TMR) ? timer_two_tick : (div_cnt == half_lim));
  wire m_lead   = ~half_cnt[0];
  wire m_done   = m_tick & (half_cnt == EDGES_PER_BYTE);
  wire m_shift  = m_tick & ~m_done & (m_lead == clock_edge_select);
  wire m_latch  = m_tick & ~m_done & (m_lead != clock_edge_select);
  wire m_late   = sample_phase_select;

  // Slave edges from the synchronised clock pin
  wire s_rise   = s_sck & ~sck_d;
  wire s_fall   = ~s_sck & sck_d;
  wire s_lead   = clock_idle_polarity ? s_fall : s_rise;
  wire s_trail  = clock_idle_polarity ? s_rise : s_fall;
  wire s_act    = is_slave & selected;
  wire s_shift  = s_act & (clock_edge_select ? s_lead : s_trail);
  wire s_latch  = s_act & (clock_edge_select ? s_trail : s_lead);
  wire s_done   = s_latch & (bit_cnt == LAST_BIT);

  // Completed byte and buffer load
  wire [7:0] m_byte = (m_late & late_pend) ? {shift_register[7:1], s_sdi} : shift_register;
  wire [7:0] s_byte = {shift_register[6:0], s_sdi};
  wire s_ovf    = s_done & buffer_full_flag;
  wire load_evt = m_done | (s_done & ~buffer_full_flag);
  wire [7:0] rx_byte = m_done ? m_byte : s_byte;
  wire monitor  = pin_dir[DIR_SCK];
  wire wr_ok    = buf_wr & ~busy;
  wire write_collision_flag_set = buf_wr & busy;

  // Read mux
  wire [7:0] rd_mux = hit_buf  ? transfer_buffer :
                      hit_ctl  ? {write_collision_flag, receive_overflow_flag, port_enable_bit,
                                  clock_idle_polarity, mode_field} :
                      hit_stat ? {sample_phase_select, clock_edge_select, 5'h00, buffer_full_flag} :
                      hit_dir  ? {5'h00, pin_dir} : 8'h00;

  // ----------------------------------------------------------------
  // APB answer: zero wait states
  // ----------------------------------------------------------------
  assign pready  = acc;
  assign pslverr = acc & ~mapped;

  // Read data captured in the setup cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (setup_rd)
      prdata <= {24'h00_0000, rd_mux};
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Control, sample phase, edge and direction bits
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      {port_enable_bit, clock_idle_polarity, mode_field} <= CTL_RESET[5:0];
      {sample_phase_select, clock_edge_select}           <= STAT_RESET[7:6];
      pin_dir                                            <= DIR_RESET;
    end
    else
    begin
      if (reg_wr & hit_ctl)
        {port_enable_bit, clock_idle_polarity, mode_field} <= pwdata[CTL_EN:0];
      if (reg_wr & hit_stat)
        {sample_phase_select, clock_edge_select} <= pwdata[ST_SMP:ST_CKE];
      if (reg_wr & hit_dir)
        pin_dir <= pwdata[DIR_SS:DIR_SCK];
    end
  end

  // Sticky flags: hardware set wins over software clear
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      write_collision_flag  <= CTL_RESET[CTL_WRITE_COLLISION_FLAG];
      receive_overflow_flag <= CTL_RESET[CTL_OV];
      buffer_full_flag      <= STAT_RESET[ST_BF];
    end
    else
    begin
      write_collision_flag  <= write_collision_flag_set |
                               ((reg_wr & hit_ctl) ? pwdata[CTL_WRITE_COLLISION_FLAG] : write_collision_flag);
      receive_overflow_flag <= s_ovf |
                               ((reg_wr & hit_ctl) ? pwdata[CTL_OV] : receive_overflow_flag);
      buffer_full_flag      <= load_evt | (buffer_full_flag & ~(buf_rd & ~read_stale));
    end
  end

  // A byte landing after the read snapshot keeps its full flag
  always_ff @(posedge clock)
  begin
    if (rst)
      read_stale <= 1'b0;
    else
      read_stale <= load_evt | (read_stale & ~setup_rd);
  end

  // Buffer: software write or received byte
  always_ff @(posedge clock)
  begin
    if (rst)
      transfer_buffer <= 8'h00;
    else if (load_evt)
      transfer_buffer <= rx_byte;
    else if (wr_ok)
      transfer_buffer <= pwdata[7:0];
  end

  // ----------------------------------------------------------------
  // Shifter state machine
  // ----------------------------------------------------------------
  ssp_state_t next_state;
  always_comb
  begin
    next_state = state;
    case (state)
      SSP_IDLE:
        if (wr_ok & is_master)
          next_state = SSP_MRUN;
        else if (s_shift | s_latch)
          next_state = SSP_SRUN;
      SSP_MRUN:
        if (m_done & ~(monitor & is_master))
          next_state = SSP_IDLE;
      SSP_SRUN:
        if (s_done)
          next_state = SSP_IDLE;
      default:
        next_state = SSP_IDLE;
    endcase
    if (~port_enable_bit)
      next_state = SSP_IDLE;
  end

  // State and counters
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state    <= SSP_IDLE;
      half_cnt <= 5'h00;
      div_cnt  <= 5'h00;
      bit_cnt  <= 4'h0;
      sck_d    <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      sck_d    <= s_sck;
      div_cnt  <= (next_state != SSP_MRUN || m_tick || wr_ok) ? 5'h00 : div_cnt + 5'h01;
      half_cnt <= (next_state != SSP_MRUN || m_done || wr_ok) ? 5'h00
                  : (m_tick ? half_cnt + 5'h01 : half_cnt);
      if (~is_slave)
        bit_cnt <= 4'h0;
      else if (s_latch)
        bit_cnt <= s_done ? 4'h0 : bit_cnt + 4'h1;
    end
  end

  // Shift register, output bit and late sample
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      shift_register <= 8'h00;
      out_bit        <= 1'b0;
      late_pend      <= 1'b0;
    end
    else if (wr_ok)
    begin
      shift_register <= pwdata[7:0];
      out_bit        <= pwdata[7];
      late_pend      <= 1'b0;
    end
    else
    begin
      if (m_shift | s_shift)
        out_bit <= shift_register[7];
      if (m_latch)
        shift_register <= {shift_register[6:0], m_late ? 1'b0 : s_sdi};
      else if (s_latch)
        shift_register <= s_byte;
      else if (m_tick & late_pend)
        shift_register[0] <= s_sdi;
      late_pend <= m_latch ? m_late : (m_tick ? 1'b0 : late_pend);
    end
  end

  // Serial clock out: idle level follows polarity bit
  always_ff @(posedge clock)
  begin
    if (rst)
      sck_out <= 1'b0;
    else if (state != SSP_MRUN || wr_ok)
      sck_out <= clock_idle_polarity;
    else if (m_tick & ~m_done)
      sck_out <= ~sck_out;
    else if (m_done)
      sck_out <= clock_idle_polarity;
  end

  // Completion events
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      port_interrupt_flag <= 1'b0;
      wake                <= 1'b0;
    end
    else
    begin
      port_interrupt_flag <= m_done | s_done;
      wake                <= s_done & sleep_mode;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  assign serial_out_pin = out_bit;
  assign sdo_oe_n = ~((is_master | (is_slave & selected)) & ~pin_dir[DIR_SDO]);
  assign sck_oe_n = ~(is_master & ~pin_dir[DIR_SCK]);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_write_collision_flag_busy_write: assert property (buf_wr && busy |=> write_collision_flag)
    else $error("write during transfer did not set collision flag");
  a_buf_kept_busy: assert property (buf_wr && busy && !load_evt |=> $stable(transfer_buffer))
    else $error("buffer changed by a discarded write");
  a_bf_after_load: assert property (load_evt |=> buffer_full_flag && transfer_buffer == $past(rx_byte))
    else $error("received byte not in buffer with full flag");
  a_bf_read_clear: assert property (buf_rd && !read_stale && !load_evt |=> !buffer_full_flag)
    else $error("buffer read did not clear full flag");
  a_master_start: assert property (wr_ok && is_master |=> state == SSP_MRUN && sck_out == clock_idle_polarity)
    else $error("master write did not start transfer");
  a_rate_div4: assert property (m_tick && !m_done && mode_field == MODE_M_DIV4 && !wr_ok
                                |=> !m_tick ##1 (m_tick || state != SSP_MRUN))
    else $error("fastest master rate not two cycles per half bit");
  a_sdo_float_ss: assert property (ss_ctl && s_ssn |-> sdo_oe_n)
    else $error("data out driven with select high");
  a_resume_point: assert property (ss_ctl && s_ssn && sck_d == s_sck |=> $stable(bit_cnt))
    else $error("bit position lost while deselected");
  a_no_master_ovf: assert property (m_done && !(reg_wr && hit_ctl) |=> receive_overflow_flag == $past(receive_overflow_flag))
    else $error("master completion changed overflow flag");
  a_slave_ovf_lose: assert property (s_ovf |=> receive_overflow_flag && $stable(transfer_buffer))
    else $error("overflow did not keep old byte");
  a_sdo_input_quiet: assert property (pin_dir[DIR_SDO] |-> sdo_oe_n)
    else $error("data out driven while configured as input");
  a_disable_release: assert property (!port_enable_bit |-> sdo_oe_n && sck_oe_n ##1 state == SSP_IDLE)
    else $error("pins held while port disabled");
  a_wake_slave: assert property (s_done && sleep_mode |=> wake && port_interrupt_flag)
    else $error("slave completion in sleep did not wake");

  c_master_byte: cover property (m_done ##1 buffer_full_flag);
  c_slave_byte:  cover property (s_done && !buffer_full_flag);
  c_overflow:    cover property (s_ovf);
  c_collision:   cover property (write_collision_flag_set);

endmodule

/* ssp_peer.sv */
// Far-side SPI device model: answers as a slave, or clocks as a master.
// Assumes clock polarity 0, edge bit 0; lines sampled on the system clock.
`timescale 1ns/100ps
module ssp_peer (
  // System
  input  wire logic clock,
  // Link lines
  input  wire logic sck_line,
  input  wire logic dut_data,
  output logic      sck_drv,
  output logic      peer_data,
  output logic      sel_n
);
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic       sck_q;

  initial
  begin
    sck_drv = 1'b0;
    sel_n   = 1'b1;
    sck_q   = 1'b0;
    tx_byte = 8'h00;
    rx_byte = 8'h00;
  end
  // Latch on the leading edge, shift out on the trailing edge
  always @(posedge clock)
  begin
    sck_q <= sck_line;
    if (sck_line && !sck_q)
      rx_byte <= {rx_byte[6:0], dut_data};
    if (!sck_line && sck_q)
      tx_byte <= {tx_byte[6:0], ~tx_byte[0]};
  end
  assign peer_data = tx_byte[7];
  // Preload the next byte to send
  task automatic load(input logic [7:0] b);
    tx_byte <= b;
  endtask
  // Clock n bits as master; the clock idles low between calls
  task automatic send(input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(posedge clock);
      sck_drv <= 1'b1;
      repeat (half) @(posedge clock);
      sck_drv <= 1'b0;
    end
  endtask
endmodule

/* testbench.sv */
// Self-checking bench for the SPI-mode serial port over APB.
// Assumes the far-side model in ssp_peer and the package constants.
`timescale 1ns/100ps
module testbench;
  import ssp_pkg::*;
  logic        clock, rst, psel, penable, pwrite, timer_two_tick, sleep_mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, sck_out, sck_oe_n, serial_out_pin, sdo_oe_n;
  logic        port_interrupt_flag, wake, sdo_last, err;
  wire         sck_line, sdo_line, peer_sck, peer_data, peer_sel_n;
  int          n_errors, checked, cycles, n_flags, n_wake, n, tk;
  logic [7:0]  lvl;
  // -----------------------------------------------------------------
  // Instances and wire resolution
  // -----------------------------------------------------------------
  assign sck_line = sck_oe_n ? peer_sck : sck_out;
  assign sdo_line = sdo_oe_n ? ~sdo_last : serial_out_pin;
  ssp_spi dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_in(sck_line), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .serial_in_pin(peer_data),
    .serial_out_pin(serial_out_pin), .sdo_oe_n(sdo_oe_n), .slave_select_n(peer_sel_n),
    .timer_two_tick(timer_two_tick), .sleep_mode(sleep_mode),
    .port_interrupt_flag(port_interrupt_flag), .wake(wake));
  ssp_peer peer_u (.clock(clock), .sck_line(sck_line), .dut_data(sdo_line),
    .sck_drv(peer_sck), .peer_data(peer_data), .sel_n(peer_sel_n));
  // -----------------------------------------------------------------
  // Clock, tick, event counting and timeout
  // -----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
  begin
    tk = (tk == 2) ? 0 : tk + 1;
    timer_two_tick <= (tk == 0);
    if (!sdo_oe_n) sdo_last <= serial_out_pin;
    if (port_interrupt_flag === 1'b1) n_flags++;
    if (wake === 1'b1) n_wake++;
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, started just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    // pready high ends this wait, or else the bench timeout
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never re-raises psel in this time step
    @(posedge clock);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h000000, exp});
  endtask
  task automatic wait_flags(input int target);
    int w;
    w = 0;
    while (n_flags < target && w < 2000)
    begin
      @(posedge clock);
      w++;
    end
    check(n_flags, target);
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, sleep_mode, timer_two_tick, sdo_last} = '0;
    {n_errors, checked, cycles, n_flags, n_wake, tk} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rchk(SSP_ADDR_CTL, CTL_RESET);
    rchk(SSP_ADDR_STAT, STAT_RESET);
    rchk(SSP_ADDR_DIR, {5'h00, DIR_RESET});
    rchk(8'h0C, 8'h00);
    check(err, 1'b1);
    // Master at osc/16: full duplex byte, collision on second write
    apb(1'b1, SSP_ADDR_DIR, 8'h04);
    apb(1'b1, SSP_ADDR_CTL, 8'h21);
    peer_u.load(8'h3C);
    apb(1'b1, SSP_ADDR_BUF, 8'hA5);
    apb(1'b1, SSP_ADDR_BUF, 8'h5A);
    wait_flags(1);
    rchk(SSP_ADDR_STAT, 8'h01);
    rchk(SSP_ADDR_BUF, 8'h3C);
    rchk(SSP_ADDR_STAT, 8'h00);
    check(peer_u.rx_byte, 8'hA5);
    rchk(SSP_ADDR_CTL, 8'hA1);
    apb(1'b1, SSP_ADDR_CTL, 8'h21);
    rchk(SSP_ADDR_CTL, 8'h21);
    // Every master rate, alternating idle polarity
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, SSP_ADDR_CTL, 8'h00);
      // Fastest rate samples late: pin synchroniser is too slow for mid-bit
      apb(1'b1, SSP_ADDR_STAT, (m == 0) ? 8'h80 : (m == 2) ? 8'h40 : 8'h00);
      apb(1'b1, SSP_ADDR_DIR, (m == 3) ? 8'h06 : 8'h04);
      apb(1'b1, SSP_ADDR_CTL, 8'h20 | 8'(m[0] << 4) | 8'(m));
      repeat (2) @(posedge clock);
      check(sck_out, m[0]);
      check(sck_oe_n, 1'b0);
      peer_u.load(8'h69 ^ 8'(m));
      apb(1'b1, SSP_ADDR_BUF, 8'h81);
      n = 0;
      while (sck_out === m[0] && n < 200)
      begin
        @(posedge clock);
        n++;
      end
      lvl = {7'h00, sck_out};
      n = 0;
      do
      begin
        @(posedge clock);
        n++;
      end
      while (sck_out === lvl[0] && n < 200);
      check(n, (m == 0) ? FOSC_DIV_A / 2 : (m == 1) ? FOSC_DIV_B / 2 : (m == 2) ? FOSC_DIV_C / 2 : 3);
      check(sdo_oe_n, (m == 3));
      wait_flags(m + 2);
      rchk(SSP_ADDR_BUF, 8'h69 ^ 8'(m));
    end
    // Slave with select control: pause mid-byte, resume, overflow
    apb(1'b1, SSP_ADDR_CTL, 8'h00);
    apb(1'b1, SSP_ADDR_DIR, 8'h05);
    apb(1'b1, SSP_ADDR_CTL, 8'h24);
    apb(1'b1, SSP_ADDR_BUF, 8'hC3);
    peer_u.load(8'h96);
    sleep_mode <= 1'b1;
    peer_u.sel_n <= 1'b0;
    repeat (6) @(posedge clock);
    check(sdo_oe_n, 1'b0);
    peer_u.send(4, 8);
    // Let the last clock edge reach the port before deselecting
    repeat (6) @(posedge clock);
    peer_u.sel_n <= 1'b1;
    repeat (6) @(posedge clock);
    check(sdo_oe_n, 1'b1);
    peer_u.sel_n <= 1'b0;
    repeat (6) @(posedge clock);
    peer_u.send(4, 8);
    repeat (12) @(posedge clock);
    check(n_flags, 6);
    check(n_wake, 1);
    check(peer_u.rx_byte, 8'hC3);
    peer_u.load(8'h77);
    peer_u.send(8, 8);
    repeat (12) @(posedge clock);
    rchk(SSP_ADDR_CTL, 8'h64);
    rchk(SSP_ADDR_BUF, 8'h96);
    check(n_flags, 7);
    report_and_stop();
  end
endmodule
